/* File: shared/stamp_pkg.sv */
// Constants and types for the multi-port timestamp capture unit.
// Assumes a 40 MHz core clock and byte-wide registers behind a two-wire port.
package stamp_pkg;
  localparam logic [7:0] OFS_CONFIG     = 8'h25;
  localparam logic [7:0] OFS_CONTROL    = 8'h26;
  localparam logic [7:0] OFS_LINE_UPPER = 8'h27;
  localparam logic [7:0] OFS_LINE_LOWER = 8'h28;
  localparam logic [7:0] OFS_STATUS     = 8'h29;
  localparam logic [7:0] OFS_P0_UPPER   = 8'h2a;
  localparam logic [7:0] OFS_P0_LOWER   = 8'h2b;

  localparam int BIT_EDGE_SEL  = 6;
  localparam int BIT_RES_LO    = 4;
  localparam int BIT_EARLY     = 3;
  localparam int BIT_FREE      = 1;
  localparam int BIT_POINT     = 0;
  localparam int BIT_HOLD      = 4;
  localparam int BIT_READY     = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h3d; // Arbitrary value.

  // Tick periods in ns, clock period in ns; the accumulator keeps the rate exact.
  localparam logic [9:0] CLK_PERIOD_NS = 10'd25;
  localparam logic [9:0] TICK_NS_0     = 10'd40;
  localparam logic [9:0] TICK_NS_1     = 10'd80;
  localparam logic [9:0] TICK_NS_2     = 10'd160;
  localparam logic [9:0] TICK_NS_3     = 10'd1000;

  typedef struct packed {
    logic       edge_sel;
    logic [1:0] res_sel;
    logic       early;
    logic       free_run;
    logic       point;
  } stamp_cfg_t;

  typedef struct packed {
    logic       hold;
    logic [3:0] enable;
  } stamp_ctl_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;
endpackage

/* File: src/serial_reg_port.sv */
// Two-wire serial target giving byte access to the register file.
// Assumes scl and sda levels arrive synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
module serial_reg_port #(
  parameter logic [6:0] DEV_ADDR = stamp_pkg::DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  // Two-wire pins
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_o,
  // Register side
  output stamp_pkg::reg_wr_t      wr_o,
  output logic [7:0]              rd_addr_o,
  input  wire logic [7:0]         rd_data_i
);
  import stamp_pkg::*;

  typedef enum {S_IDLE, S_ADDR, S_PTR, S_WR, S_RD, S_ACK, S_MACK} st_t;

  st_t        st_q, st_d, nxt_q, nxt_d;
  logic       scl_q, sda_q, oe_q, oe_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic       rise, fall, start, stop;
  reg_wr_t    wr_q, wr_d;

  assign rise  = scl_i & ~scl_q;
  assign fall  = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop  = scl_i & scl_q & ~sda_q & sda_i;

  always_comb begin
    st_d  = st_q;
    nxt_d = nxt_q;
    oe_d  = oe_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    wr_d  = '{wr: 1'b0, addr: ptr_q, data: sh_q};
    if (start) begin
      st_d  = S_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else if (stop) begin
      st_d = S_IDLE;
      oe_d = 1'b0;
    end else if (rise) begin
      case (st_q)
        S_ADDR, S_PTR, S_WR: begin
          sh_d  = {sh_q[6:0], sda_i};
          cnt_d = cnt_q + 4'h1;
        end
        S_RD: cnt_d = cnt_q + 4'h1;
        S_MACK: begin
          st_d  = sda_i ? S_IDLE : S_ACK;
          nxt_d = S_RD;
        end
        default: ;
      endcase
    end else if (fall) begin
      case (st_q)
        S_ADDR, S_PTR, S_WR: begin
          if (cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            oe_d  = 1'b1;
            st_d  = S_ACK;
            nxt_d = S_WR;
            if (st_q == S_ADDR) begin
              nxt_d = sh_q[0] ? S_RD : S_PTR;
              if (sh_q[7:1] != DEV_ADDR) begin
                oe_d = 1'b0;
                st_d = S_IDLE;
              end
            end else if (st_q == S_PTR) begin
              ptr_d = sh_q;
            end else begin
              wr_d.wr = 1'b1;
              ptr_d   = ptr_q + 8'h01;
            end
          end
        end
        S_ACK: begin
          st_d  = nxt_q;
          cnt_d = 4'h0;
          oe_d  = 1'b0;
          if (nxt_q == S_RD) begin
            sh_d  = rd_data_i;
            oe_d  = ~rd_data_i[7];
            ptr_d = ptr_q + 8'h01;
          end
        end
        S_RD: begin
          if (cnt_q == 4'h8) begin
            oe_d  = 1'b0;
            cnt_d = 4'h0;
            st_d  = S_MACK;
          end else begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q  <= S_IDLE;
      nxt_q <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      oe_q  <= 1'b0;
      cnt_q <= 4'h0;
      sh_q  <= RESET_BYTE;
      ptr_q <= RESET_BYTE;
      wr_q  <= '0;
    end else begin
      st_q  <= st_d;
      nxt_q <= nxt_d;
      scl_q <= scl_i;
      sda_q <= sda_i;
      oe_q  <= oe_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      ptr_q <= ptr_d;
      wr_q  <= wr_d;
    end
  end

  // Open drain: the pin is only ever pulled low.
  assign sda_o     = 1'b0;
  assign sda_oe_o  = oe_q;
  assign wr_o      = wr_q;
  assign rd_addr_o = ptr_q;
endmodule
`default_nettype wire

/* File: src/stamp_capture.sv */
// Top of the four-port timestamp capture unit with its register file.
// Assumes per-port frame-start and line-start pulses of one clock each.
`timescale 1ns/10ps
`default_nettype none
module stamp_capture #(
  parameter int PORTS = 4
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // Two-wire register port
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  // Video timing
  input  wire logic             frame_sync_i,
  input  wire logic [PORTS-1:0] frame_start_i,
  input  wire logic [PORTS-1:0] line_start_i,
  // Status
  output logic                  captures_ready_o
);
  import stamp_pkg::*;

  reg_wr_t     wr;
  logic [7:0]  rd_addr, rd_data;
  logic        sda_drv, sda_en;

  serial_reg_port i_serial_reg_port (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_o     (sda_drv),
    .sda_oe_o  (sda_en),
    .wr_o      (wr),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data)
  );

  function automatic logic [9:0] tick_ns(input logic [1:0] sel);
    case (sel)
      2'b00:   tick_ns = TICK_NS_0;
      2'b01:   tick_ns = TICK_NS_1;
      2'b10:   tick_ns = TICK_NS_2;
      default: tick_ns = TICK_NS_3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers written over the two-wire port.

  stamp_cfg_t  cfg_q, cfg_d;
  stamp_ctl_t  ctl_q, ctl_d;
  logic [15:0] line_q, line_d;

  always_comb begin
    cfg_d  = cfg_q;
    ctl_d  = ctl_q;
    line_d = line_q;
    if (wr.wr) begin
      case (wr.addr)
        OFS_CONFIG: cfg_d = '{edge_sel: wr.data[BIT_EDGE_SEL],
                              res_sel:  wr.data[BIT_RES_LO+:2],
                              early:    wr.data[BIT_EARLY],
                              free_run: wr.data[BIT_FREE],
                              point:    wr.data[BIT_POINT]};
        OFS_CONTROL:    ctl_d = {wr.data[BIT_HOLD], wr.data[3:0]};
        OFS_LINE_UPPER: line_d[15:8] = wr.data;
        OFS_LINE_LOWER: line_d[7:0] = wr.data;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared timestamp counter.

  logic        fs_q, fs_edge, tick;
  logic [9:0]  acc_q, acc_d, acc_sum;
  logic [15:0] cnt_q, cnt_d;

  assign fs_edge = cfg_q.edge_sel ? (fs_q & ~frame_sync_i)
                                  : (~fs_q & frame_sync_i);
  assign acc_sum = acc_q + CLK_PERIOD_NS;
  assign tick    = acc_sum >= tick_ns(cfg_q.res_sel);

  // A 25 ns clock cannot divide to 40 ns evenly, so a ns accumulator keeps
  // the mean tick rate exact at the cost of up to one cycle of jitter.
  always_comb begin
    acc_d = tick ? acc_sum - tick_ns(cfg_q.res_sel) : acc_sum;
    cnt_d = tick ? cnt_q + 16'h0001 : cnt_q;
    if (!cfg_q.free_run && fs_edge) begin
      acc_d = '0;
      cnt_d = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port line tracking and capture.

  logic [15:0] lines_q [PORTS], lines_d [PORTS];
  logic [15:0] stamp_q [PORTS], stamp_d [PORTS];
  logic [PORTS-1:0] armed_q, armed_d, valid_q, valid_d, hit;
  logic        hold_q, ready_q, ready_d, all_valid;

  assign all_valid = (ctl_q.enable != '0) &&
                     ((valid_d & ctl_q.enable) == ctl_q.enable);

  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      lines_d[p] = lines_q[p];
      stamp_d[p] = stamp_q[p];
      // Disabling a port drops a pending arm, so a stale line count cannot fire later.
      armed_d[p] = armed_q[p] & ctl_q.enable[p];
      valid_d[p] = valid_q[p] & ctl_q.enable[p];
      hit[p]     = 1'b0;
      if (frame_start_i[p]) begin
        lines_d[p] = '0;
      end else if (line_start_i[p]) begin
        lines_d[p] = lines_q[p] + 16'h0001;
        if (lines_d[p] == line_q) begin
          armed_d[p] = 1'b1;
        end
      end
      if (!cfg_q.point) begin
        hit[p] = line_start_i[p] && (lines_d[p] == line_q);
      end else begin
        hit[p] = frame_start_i[p] && (!cfg_q.free_run || armed_q[p]);
        if (hit[p]) begin
          armed_d[p] = 1'b0;
        end
      end
      // The clear on hold release comes first, so a capture in that cycle wins.
      if (hold_q && !ctl_q.hold) begin
        valid_d[p] = 1'b0;
      end
      if (hit[p] && ctl_q.enable[p] && !ctl_q.hold) begin
        stamp_d[p] = cnt_q;
        valid_d[p] = 1'b1;
      end
    end
    ready_d = ready_q;
    if (ctl_q.hold) begin
      ready_d = 1'b0;
    end else if (all_valid && (cfg_q.early || cfg_q.free_run)) begin
      ready_d = 1'b1;
    end else if (all_valid && fs_edge) begin
      ready_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q   <= '0;
      ctl_q   <= '0;
      line_q  <= '0;
      fs_q    <= 1'b0;
      acc_q   <= '0;
      cnt_q   <= '0;
      armed_q <= '0;
      valid_q <= '0;
      hold_q  <= 1'b0;
      ready_q <= 1'b0;
      for (int p = 0; p < PORTS; p++) begin
        lines_q[p] <= '0;
        stamp_q[p] <= '0;
      end
    end else begin
      cfg_q   <= cfg_d;
      ctl_q   <= ctl_d;
      line_q  <= line_d;
      fs_q    <= frame_sync_i;
      acc_q   <= acc_d;
      cnt_q   <= cnt_d;
      armed_q <= armed_d;
      valid_q <= valid_d;
      hold_q  <= ctl_q.hold;
      ready_q <= ready_d;
      for (int p = 0; p < PORTS; p++) begin
        lines_q[p] <= lines_d[p];
        stamp_q[p] <= stamp_d[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits and unmapped offsets read zero.

  always_comb begin
    rd_data = RESET_BYTE;
    case (rd_addr)
      OFS_CONFIG: begin
        rd_data[BIT_EDGE_SEL]   = cfg_q.edge_sel;
        rd_data[BIT_RES_LO+:2]  = cfg_q.res_sel;
        rd_data[BIT_EARLY]      = cfg_q.early;
        rd_data[BIT_FREE]       = cfg_q.free_run;
        rd_data[BIT_POINT]      = cfg_q.point;
      end
      OFS_CONTROL:    rd_data[4:0] = ctl_q;
      OFS_LINE_UPPER: rd_data = line_q[15:8];
      OFS_LINE_LOWER: rd_data = line_q[7:0];
      OFS_STATUS: begin
        rd_data[BIT_READY] = ready_q;
        rd_data[3:0]       = valid_q[3:0];
      end
      OFS_P0_UPPER: rd_data = stamp_q[0][15:8];
      OFS_P0_LOWER: rd_data = stamp_q[0][7:0];
      default: ;
    endcase
  end

  assign sda_o            = sda_drv;
  assign sda_oe_o         = sda_en;
  assign captures_ready_o = ready_q;
endmodule
`default_nettype wire

/* File: bench/stamp_capture_asserts.sv */
// Checker for the timestamp capture unit, bound to its top module.
// Assumes one core clock domain and the asynchronous reset rst_i.
`timescale 1ns/10ps
`default_nettype none
module stamp_capture_asserts #(
  parameter int PORTS = 4
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // Two-wire pins
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  input  wire logic             sda_o,
  input  wire logic             sda_oe_o,
  // Video timing and status
  input  wire logic             frame_sync_i,
  input  wire logic [PORTS-1:0] frame_start_i,
  input  wire logic [PORTS-1:0] line_start_i,
  input  wire logic             captures_ready_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Cycles since the last video event; ready may only rise shortly after one.
  logic [3:0] since_q, since_d;
  logic       sync_q;
  always_comb begin
    since_d = (since_q == 4'hf) ? since_q : since_q + 4'h1;
    if ((|frame_start_i) || (|line_start_i) || (frame_sync_i != sync_q)) begin
      since_d = 4'h0;
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      since_q <= 4'hf;
      sync_q  <= 1'b0;
    end else begin
      since_q <= since_d;
      sync_q  <= frame_sync_i;
    end
  end
  a_sda_value_zero: assert property (sda_o == 1'b0)
    else $error("sda drive value not low");
  a_reset_clear_out: assert property ($fell(rst_i) |-> !captures_ready_o && !sda_oe_o)
    else $error("outputs not clear after reset");
  a_ack_after_fall: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("sda drive began outside scl low");
  a_oe_release_low: assert property ($fell(sda_oe_o) |-> !scl_i)
    else $error("sda released while scl high");
  a_oe_steady_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("sda drive changed while scl high");
  a_ack_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o [*3])
    else $error("sda drive too short");
  a_ready_has_cause: assert property ($rose(captures_ready_o) |-> since_q <= 4'h4)
    else $error("ready rose without video event");
  a_ready_fall_write: assert property ($fell(captures_ready_o) |-> !scl_i)
    else $error("ready fell outside a register write");
  cover property ($rose(captures_ready_o));
  cover property ($fell(captures_ready_o));
  cover property ($rose(sda_oe_o));
endmodule
bind stamp_capture stamp_capture_asserts #(.PORTS(PORTS)) i_stamp_capture_asserts (.*);
`default_nettype wire

/* File: bench/i2c_host_model.sv */
// Two-wire bus host model that writes and reads device registers.
// Assumes the bench resolves the open-drain wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = stamp_pkg::DEV_ADDR_DEFAULT
) (
  // Clock
  input  wire logic clk_sys_i,
  // Two-wire pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Four core clocks a quarter keep scl slow against the core clock.
  task automatic q;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic bit_out(input logic b);
    sda_pull_o <= !b;
    q();
    scl_o <= 1'b1;
    q();
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic bit_in(output logic b);
    sda_pull_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    b = sda_i;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic start;
    sda_pull_o <= 1'b0;
    scl_o      <= 1'b1;
    q();
    sda_pull_o <= 1'b1;
    q();
    scl_o <= 1'b0;
    q();
  endtask
  task automatic stop;
    sda_pull_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_pull_o <= 1'b0;
    q();
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = !b;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic a0, a1, a2;
    start();
    byte_out({dev, 1'b0}, a0);
    byte_out(a, a1);
    byte_out(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic a0, a1, a2, b;
    start();
    byte_out({DEV_ADDR, 1'b0}, a0);
    byte_out(a, a1);
    start();
    byte_out({DEV_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    // A final nack sends the device back to idle, so it drives no further byte.
    bit_out(1'b1);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_multi_port_timestamp_capture.sv */
// Self-checking bench for the timestamp capture unit.
// Assumes the host model owns the two-wire pins and the bench drives video timing.
`timescale 1ns/10ps
`default_nettype none
module tb_multi_port_timestamp_capture;
  import stamp_pkg::*;
  logic       clk_sys_i     = 1'b0;
  logic       rst_i         = 1'b1;
  logic       frame_sync_i  = 1'b0;
  logic [3:0] frame_start_i = 4'h0;
  logic [3:0] line_start_i  = 4'h0;
  logic       scl, sda_pull, sda_o, sda_oe_o, wire_sda, ready, ack;
  int         failures      = 0;
  int         n_tests       = 0;
  // Address, value read first, value written, value read back.
  localparam logic [7:0] ROWS [10][4] = '{'{8'h25, 8'h00, 8'hff, 8'h7b},
    '{8'h26, 8'h00, 8'hef, 8'h0f}, '{8'h27, 8'h00, 8'ha5, 8'ha5}, '{8'h28, 8'h00, 8'h5a, 8'h5a},
    '{8'h29, 8'h00, 8'hff, 8'h00}, '{8'h2a, 8'h00, 8'hff, 8'h00}, '{8'h2b, 8'h00, 8'hff, 8'h00},
    '{8'h40, 8'h00, 8'hff, 8'h00}, '{8'h25, 8'h7b, 8'h00, 8'h00}, '{8'h26, 8'h0f, 8'h00, 8'h00}};
  assign wire_sda = !(sda_pull || (sda_oe_o && !sda_o));
  stamp_capture i_stamp_capture (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(wire_sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .frame_sync_i(frame_sync_i),
    .frame_start_i(frame_start_i), .line_start_i(line_start_i), .captures_ready_o(ready));
  i2c_host_model i_i2c_host_model (.clk_sys_i(clk_sys_i), .sda_i(wire_sda), .scl_o(scl),
    .sda_pull_o(sda_pull));
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_of_test;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    i_i2c_host_model.read_reg(a, d, ok);
    chk({7'h0, ok}, 8'h01);
    chk(d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_i2c_host_model.write_reg(DEV_ADDR_DEFAULT, a, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  // Active edge at T, inactive edge and frame start at T+100, lines at T+135, 170 and 205.
  task automatic frame(input logic [3:0] m, input logic lvl);
    frame_sync_i <= !lvl;
    repeat (5) @(posedge clk_sys_i);
    frame_sync_i <= lvl;
    repeat (100) @(posedge clk_sys_i);
    frame_sync_i  <= !lvl;
    frame_start_i <= m;
    @(posedge clk_sys_i);
    frame_start_i <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      repeat (34) @(posedge clk_sys_i);
      line_start_i <= m;
      @(posedge clk_sys_i);
      line_start_i <= 4'h0;
    end
    repeat (20) @(posedge clk_sys_i);
  endtask
  initial begin
    #1500000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk({7'h0, ready}, 8'h00);
    for (int r = 0; r < 10; r++) begin
      rd(ROWS[r][0], ROWS[r][1]);
      wr(ROWS[r][0], ROWS[r][2]);
      rd(ROWS[r][0], ROWS[r][3]);
    end
    i_i2c_host_model.write_reg(DEV_ADDR_DEFAULT ^ 7'h01, OFS_CONFIG, 8'h38, ack);
    chk({7'h0, ack}, 8'h00);
    rd(OFS_CONFIG, 8'h00);
    // The register rows left a nonzero upper line byte behind.
    wr(OFS_LINE_UPPER, 8'h00);
    // Slowest tick of 40 clocks keeps the expected counts clear of off-by-one latency.
    wr(OFS_CONFIG, 8'h38);
    wr(OFS_LINE_LOWER, 8'h03);
    wr(OFS_CONTROL, 8'h01);
    frame(4'h1, 1'b1);
    rd(OFS_P0_UPPER, 8'h00);
    rd(OFS_P0_LOWER, 8'h05);
    rd(OFS_STATUS, 8'h11);
    chk({7'h0, ready}, 8'h01);
    wr(OFS_CONTROL, 8'h11);
    chk({7'h0, ready}, 8'h00);
    rd(OFS_STATUS, 8'h01);
    wr(OFS_LINE_LOWER, 8'h02);
    frame(4'h1, 1'b1);
    rd(OFS_P0_LOWER, 8'h05);
    wr(OFS_CONTROL, 8'h01);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_CONFIG, 8'h78);
    frame(4'h1, 1'b0);
    rd(OFS_P0_LOWER, 8'h04);
    rd(OFS_STATUS, 8'h11);
    wr(OFS_CONTROL, 8'h02);
    frame(4'h1, 1'b0);
    rd(OFS_STATUS, 8'h10);
    frame(4'h2, 1'b0);
    rd(OFS_STATUS, 8'h12);
    wr(OFS_CONFIG, 8'h79);
    wr(OFS_CONTROL, 8'h01);
    frame(4'h1, 1'b0);
    rd(OFS_P0_LOWER, 8'h02);
    wr(OFS_CONFIG, 8'h3b);
    wr(OFS_CONTROL, 8'h10);
    wr(OFS_CONTROL, 8'h01);
    frame(4'h1, 1'b1);
    rd(OFS_STATUS, 8'h00);
    frame(4'h1, 1'b1);
    rd(OFS_STATUS, 8'h11);
    // Normal ready waits for the next active sync edge; each faster tick code gets one frame.
    wr(OFS_CONTROL, 8'h11);
    wr(OFS_CONFIG, 8'h10);
    wr(OFS_CONTROL, 8'h01);
    frame(4'h1, 1'b1);
    rd(OFS_P0_LOWER, 8'h34);
    rd(OFS_STATUS, 8'h01);
    wr(OFS_CONFIG, 8'h20);
    frame(4'h1, 1'b1);
    rd(OFS_P0_LOWER, 8'h1a);
    rd(OFS_STATUS, 8'h11);
    wr(OFS_CONFIG, 8'h00);
    frame(4'h1, 1'b1);
    rd(OFS_P0_LOWER, 8'h69);
    end_of_test();
  end
endmodule
`default_nettype wire
